// >>> inc/pir_pkg.sv
// Shared constants and types for the infrared detector readout line
package pir_pkg;

  localparam int HCLK_PERIOD_NS = 10;
  // Internal detector clock, nominally 32 kHz
  localparam int INT_CLK_PERIOD_NS = 31250;
  localparam int TICK_CYCLES = INT_CLK_PERIOD_NS / HCLK_PERIOD_NS;
  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

  // Link intervals in internal clock ticks
  localparam logic [2:0] SETUP_TICKS = 3'h3;
  localparam logic [2:0] BIT_END_TICKS = 3'h2;
  localparam logic [2:0] ABORT_TICKS = 3'h4;
  localparam logic [5:0] FRAME_MAX_TICKS = 6'h20;
  localparam logic [8:0] SAMPLE_LAST = 9'h1FF;
  localparam logic [9:0] SHORT_TICKS = 10'h200;

  // Converter limits
  localparam logic [13:0] ADC_HIGH = 14'h3E00;
  localparam logic [13:0] ADC_LOW = 14'h01FF;
  localparam logic [13:0] ADC_SPAN_TOP = 14'h3E01;

  localparam logic [5:0] FRAME_TOP = 6'h27;
  localparam int CFG_BITS = 25;
  localparam logic [24:0] CONFIG_RESET = 25'h0000010;

  // Register byte offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_SAMPLE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // Status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_BLIND = 2;
  localparam int ST_SHORT = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_ABORT = 5;
  localparam int ST_INDEX = 8;

  localparam logic [1:0] MODE_FORCED = 2'h0;
  localparam logic [1:0] MODE_PERIODIC = 2'h1;
  localparam logic [1:0] MODE_WAKE = 2'h2;
  localparam logic [1:0] SRC_BAND_PASS = 2'h0;

  typedef struct packed {
    logic [7:0] sensitivity;
    logic [3:0] blind;
    logic [1:0] pulses;
    logic [1:0] window;
    logic [1:0] mode;
    logic [1:0] source;
    logic [4:0] reserved;
  } cfg_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] addr;
  } ahb_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_ARMED = 4'b0100,
    ST_SHIFT = 4'b1000
  } link_state_t;

endpackage

// >>> rtl/line_sync.sv
// Two-flop synchroniser with edge detection for the shared line
`timescale 1ns/1ps
`default_nettype none
module line_sync (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic din, // Raw pin level
  output logic level, // Synchronised level
  output logic rise, // One-cycle pulse on low to high
  output logic fall // One-cycle pulse on high to low
);

  logic meta;
  logic prev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      level <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= din;
      level <= meta;
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule
`default_nettype wire

// >>> rtl/pir_single_wire_readout.sv
// Single-wire readout and interrupt line of the infrared detector, AHB-Lite registers
// Operation
// - Frame is 40 bits, MSB first: reserved bit, 14-bit sample, 25 config bits.
// - Bits 38..25 hold the sample, two's complement for band-pass, else unsigned.
// - Bits 24..0 repeat the configuration register in programming order.
// - Each host rising strobe presents the next bit; device then waits again.
// - Line low four ticks ends a readout early; device drops the frame.
// - Periodic mode drives a sample-ready high every 512 internal ticks.
// - Wake mode drives the line high on motion and holds it until cleared.
// - After clearing, motion detection is blocked for the blind interval.
// - No interrupt is raised while the host accesses the line.
// - Sample above 15872 or below 511 shorts converter input 512 ticks.
// - Stored samples are held between 511 and 2^14 minus 511.
// - Mode field: 0 no interrupts, 1 periodic, 2 motion wake-up, 3 reserved.
// - Blind interval is 0.5 s times one plus the blind field.
`timescale 1ns/1ps
`default_nettype none
module pir_single_wire_readout #(
  parameter int BLIND_UNIT_TICKS = 16000
) (
  input wire logic hclk, // System clock, 100 MHz
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  input wire logic line_in, // Shared readout line, sensed level
  output logic line_out, // Shared readout line, driven level
  output logic line_oe, // High while the device drives the line
  input wire logic [13:0] adc_value, // Converter result
  input wire logic adc_valid, // One-cycle strobe with adc_value
  input wire logic motion_detect, // One-cycle pulse, motion criteria met
  output logic adc_short // Converter input shorted while high
);
  // Offset binary to two's complement for band-pass data
  function automatic logic [13:0] adc_code(input logic [13:0] v, input logic [1:0] src);
    adc_code = (src == pir_pkg::SRC_BAND_PASS) ? {~v[13], v[12:0]} : v;
  endfunction
  function automatic logic [17:0] blind_ticks(input logic [3:0] field);
    logic [31:0] prod;
    prod = (32'(field) + 32'h1) * 32'(BLIND_UNIT_TICKS);
    blind_ticks = prod[17:0];
  endfunction
  pir_pkg::cfg_t cfg;
  pir_pkg::ahb_req_t req;
  pir_pkg::link_state_t state;
  pir_pkg::link_state_t next_state;
  logic [11:0] tick_cnt;
  logic [2:0] setup_cnt;
  logic [2:0] bit_ticks;
  logic [5:0] frame_ticks;
  logic [5:0] bit_idx;
  logic last_bit;
  logic [39:0] frame;
  logic [13:0] adc_hold;
  logic [8:0] sample_cnt;
  logic [9:0] short_cnt;
  logic [17:0] blind_cnt;
  logic pulse_on;
  logic alarm;
  logic motion_pend;
  logic overrun;
  logic abort_flag;
  logic data_bit;
  logic line_lvl;
  logic line_rise;
  logic line_fall;
  line_sync u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .din(line_in),
    .level(line_lvl),
    .rise(line_rise),
    .fall(line_fall)
  );
  // Internal clock tick
  wire tick = (tick_cnt == pir_pkg::TICK_LAST);
  wire idle = (state == pir_pkg::ST_IDLE);
  wire busy = ~idle;
  // Interrupt line drive, only when no access is running
  wire irq_drive = idle & (pulse_on | alarm);
  wire mode_periodic = (cfg.mode == pir_pkg::MODE_PERIODIC);
  wire mode_wake = (cfg.mode == pir_pkg::MODE_WAKE);
  wire blind_on = (blind_cnt != 18'h0);
  // Start of an access: host holds the line high while we release it
  wire start_seen = idle & line_lvl & ~irq_drive;
  wire setup_done = tick & (setup_cnt == pir_pkg::SETUP_TICKS - 3'h1);
  wire strobe = line_rise & (state == pir_pkg::ST_ARMED || state == pir_pkg::ST_SHIFT);
  wire low_abort = tick & ~line_lvl & (bit_ticks >= pir_pkg::ABORT_TICKS - 3'h1);
  wire frame_end = tick & last_bit & (bit_ticks == pir_pkg::BIT_END_TICKS - 3'h1);
  wire link_abort = (state == pir_pkg::ST_ARMED || state == pir_pkg::ST_SHIFT) & low_abort;
  // Alarm clear: host pulls low across a tick while we drive high
  wire alarm_clear = alarm & idle & tick & ~line_lvl;
  wire motion_set = mode_wake & motion_detect & ~blind_on;
  wire sample_wrap = tick & (sample_cnt == pir_pkg::SAMPLE_LAST);
  // Out-of-range and span handling of converter samples
  wire adc_over = adc_value > pir_pkg::ADC_HIGH;
  wire adc_under = adc_value < pir_pkg::ADC_LOW;
  wire [13:0] adc_clamped = adc_under ? pir_pkg::ADC_LOW :
    (adc_value > pir_pkg::ADC_SPAN_TOP) ? pir_pkg::ADC_SPAN_TOP : adc_value;
  // Bus decode
  wire addr_phase = hsel & hready & htrans[1];
  wire do_write = req.valid & req.wr;
  wire wr_config = do_write & (req.addr == pir_pkg::REG_CONFIG);
  wire wr_status = do_write & (req.addr == pir_pkg::REG_STATUS);
  wire [7:0] rd_addr = haddr[7:0];
  wire rd_hit = addr_phase & ~hwrite & (haddr[31:8] == 24'h0);
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic next_line_oe;
  logic next_line_out;
  always_comb begin
    status_word = 32'h0;
    status_word[pir_pkg::ST_BUSY] = busy;
    status_word[pir_pkg::ST_ALARM] = alarm;
    status_word[pir_pkg::ST_BLIND] = blind_on;
    status_word[pir_pkg::ST_SHORT] = adc_short;
    status_word[pir_pkg::ST_OVERRUN] = overrun;
    status_word[pir_pkg::ST_ABORT] = abort_flag;
    status_word[pir_pkg::ST_INDEX +: 6] = bit_idx;
  end
  always_comb begin
    unique case (rd_addr)
      pir_pkg::REG_CONFIG: rd_mux = {7'h0, cfg};
      pir_pkg::REG_SAMPLE: rd_mux = {18'h0, adc_hold};
      pir_pkg::REG_STATUS: rd_mux = status_word;
      default: rd_mux = 32'h0;
    endcase
  end

  // Link state machine
  always_comb begin
    next_state = state;
    unique case (state)
      pir_pkg::ST_IDLE: begin
        if (start_seen) begin
          next_state = pir_pkg::ST_SETUP;
        end
      end
      pir_pkg::ST_SETUP: begin
        if (!line_lvl) begin
          next_state = pir_pkg::ST_IDLE;
        end else if (setup_done) begin
          next_state = pir_pkg::ST_ARMED;
        end
      end
      pir_pkg::ST_ARMED: begin
        if (link_abort) begin
          next_state = pir_pkg::ST_IDLE;
        end else if (strobe) begin
          next_state = pir_pkg::ST_SHIFT;
        end
      end
      pir_pkg::ST_SHIFT: begin
        if (link_abort || frame_end) begin
          next_state = pir_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Line drive: data bit during a frame, interrupt level otherwise
  always_comb begin
    next_line_oe = irq_drive;
    next_line_out = irq_drive;
    if (state == pir_pkg::ST_SHIFT) begin
      next_line_oe = ~(line_fall | link_abort | frame_end) & line_oe;
      next_line_out = data_bit;
    end
    if (strobe) begin
      next_line_oe = 1'b1;
      next_line_out = frame[bit_idx];
    end
    if (next_state == pir_pkg::ST_IDLE && state != pir_pkg::ST_IDLE) begin
      next_line_oe = 1'b0;
      next_line_out = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= 12'h0;
    end else begin
      tick_cnt <= tick ? 12'h0 : tick_cnt + 12'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= pir_pkg::ST_IDLE;
      line_oe <= 1'b0;
      line_out <= 1'b0;
      data_bit <= 1'b0;
    end else begin
      state <= next_state;
      line_oe <= next_line_oe;
      line_out <= next_line_out;
      if (strobe) begin
        data_bit <= frame[bit_idx];
      end
    end
  end

  // Setup timing and frame snapshot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setup_cnt <= 3'h0;
      frame <= 40'h0;
    end else begin
      if (state != pir_pkg::ST_SETUP) begin
        setup_cnt <= 3'h0;
      end else if (tick) begin
        setup_cnt <= setup_cnt + 3'h1;
      end
      if (setup_done) begin
        frame <= {1'b0, adc_code(adc_hold, cfg.source), cfg};
      end
    end
  end

  // Bit index and per-bit timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_idx <= pir_pkg::FRAME_TOP;
      last_bit <= 1'b0;
      bit_ticks <= 3'h0;
      frame_ticks <= 6'h0;
    end else begin
      if (idle || state == pir_pkg::ST_SETUP) begin
        bit_idx <= pir_pkg::FRAME_TOP;
        last_bit <= 1'b0;
      end else if (strobe) begin
        last_bit <= (bit_idx == 6'h0);
        if (bit_idx != 6'h0) begin
          bit_idx <= bit_idx - 6'h1;
        end
      end
      if (strobe || state == pir_pkg::ST_SETUP) begin
        bit_ticks <= 3'h0;
      end else if (tick && bit_ticks != 3'h7) begin
        bit_ticks <= bit_ticks + 3'h1;
      end
      if (idle) begin
        frame_ticks <= 6'h0;
      end else if (tick && frame_ticks != 6'h3F) begin
        frame_ticks <= frame_ticks + 6'h1;
      end
    end
  end

  // Sticky link errors; a new event wins over a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun <= 1'b0;
      abort_flag <= 1'b0;
    end else begin
      overrun <= (busy & (frame_ticks >= pir_pkg::FRAME_MAX_TICKS)) |
        (overrun & ~(wr_status & hwdata[pir_pkg::ST_OVERRUN]));
      abort_flag <= link_abort |
        (abort_flag & ~(wr_status & hwdata[pir_pkg::ST_ABORT]));
    end
  end

  // Sample-ready pulse and motion alarm
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_cnt <= 9'h0;
      pulse_on <= 1'b0;
      motion_pend <= 1'b0;
      alarm <= 1'b0;
      blind_cnt <= 18'h0;
    end else begin
      if (tick) begin
        sample_cnt <= sample_cnt + 9'h1;
      end
      // Pulse lasts one tick; skipped if an access is running
      if (sample_wrap) begin
        pulse_on <= mode_periodic & idle;
      end else if (tick || busy) begin
        pulse_on <= 1'b0;
      end
      // Motion during an access is held until the line is free
      if (!mode_wake) begin
        motion_pend <= 1'b0;
      end else if (motion_set && busy) begin
        motion_pend <= 1'b1;
      end else if (idle) begin
        motion_pend <= 1'b0;
      end
      if (!mode_wake || alarm_clear) begin
        alarm <= 1'b0;
      end else if (idle && (motion_set || motion_pend)) begin
        alarm <= 1'b1;
      end
      if (alarm_clear) begin
        blind_cnt <= blind_ticks(cfg.blind);
      end else if (tick && blind_on) begin
        blind_cnt <= blind_cnt - 18'h1;
      end
    end
  end

  // Converter sample and out-of-range short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_hold <= pir_pkg::ADC_LOW;
      short_cnt <= 10'h0;
      adc_short <= 1'b0;
    end else begin
      if (adc_valid) begin
        adc_hold <= adc_clamped;
      end
      if (adc_valid && (adc_over || adc_under)) begin
        short_cnt <= pir_pkg::SHORT_TICKS;
      end else if (tick && short_cnt != 10'h0) begin
        short_cnt <= short_cnt - 10'h1;
      end
      adc_short <= (adc_valid & (adc_over | adc_under)) |
        (short_cnt > 10'h1) | ((short_cnt == 10'h1) & ~tick);
    end
  end

  // AHB-Lite slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        req.valid <= addr_phase;
        req.wr <= hwrite;
        req.addr <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF;
      end
      hrdata <= rd_hit ? rd_mux : 32'h0;
    end
  end

  // Configuration register, steers mode, source and blind time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= pir_pkg::CONFIG_RESET;
    end else if (wr_config) begin
      cfg <= hwdata[pir_pkg::CFG_BITS-1:0];
    end
  end

endmodule
`default_nettype wire

// >>> testbench/pir_chk.sv
// Port-level assertions for the readout line block
`timescale 1ns/1ps
`default_nettype none
module pir_chk #(
  parameter int BLIND_UNIT_TICKS = 16000
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Ready in
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Ready out
  input wire logic hresp, // Response
  input wire logic line_in, // Line level
  input wire logic line_out, // Drive level
  input wire logic line_oe, // Drive enable
  input wire logic [13:0] adc_value, // Sample
  input wire logic adc_valid, // Sample strobe
  input wire logic adc_short // Short
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_q;
  logic wr_q;
  logic [31:0] addr_q;
  logic [24:0] cfg;
  int unsigned quiet;
  wire take = hsel && hready && htrans[1];
  wire wake = cfg[8:7] == pir_pkg::MODE_WAKE;
  wire bad = adc_value > pir_pkg::ADC_HIGH || adc_value < pir_pkg::ADC_LOW;
  wire [31:0] blind = (cfg[16:13] + 1) * BLIND_UNIT_TICKS * pir_pkg::TICK_CYCLES;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= '0;
      cfg <= pir_pkg::CONFIG_RESET;
      quiet <= '1;
    end else begin
      rd_q <= take && !hwrite;
      wr_q <= take && hwrite;
      addr_q <= haddr;
      if (wr_q && addr_q == 32'(pir_pkg::REG_CONFIG)) cfg <= hwdata[24:0];
      // Blind time runs from the edge where the alarm drive is dropped
      if (wake && $fell(line_oe) && !line_in) quiet <= '0;
      else if (quiet != '1) quiet <= quiet + 1;
    end
  end
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  short_start_a: assert property (adc_valid && bad |=> adc_short)
    else $error("out of range sample did not short the input");
  short_cause_a: assert property ($rose(adc_short) |-> $past(adc_valid) && $past(bad))
    else $error("input shorted without an out of range sample");
  short_hold_a: assert property ($rose(adc_short) |=> adc_short [*8])
    else $error("input short ended too soon");
  sample_clamp_a: assert property (rd_q && addr_q == 32'(pir_pkg::REG_SAMPLE) |->
    hrdata >= 32'h000001FF && hrdata <= 32'h00003E01) else $error("sample outside span");
  cfg_echo_a: assert property (rd_q && addr_q == 32'(pir_pkg::REG_CONFIG) |->
    hrdata == {7'h00, cfg}) else $error("config read differs from written value");
  unmapped_zero_a: assert property (!rd_q || addr_q > 32'h00000008 |-> hrdata == 32'h0)
    else $error("read data outside a mapped read");
  forced_quiet_a: assert property (cfg[8:7] == pir_pkg::MODE_FORCED && $rose(line_oe)
    |-> $past(line_in)) else $error("line driven without a host strobe");
  alarm_hold_a: assert property (wake && line_oe && line_out && line_in |=> line_oe)
    else $error("alarm dropped before a host clear");
  blind_quiet_a: assert property (wake && quiet < blind - pir_pkg::TICK_CYCLES
    |-> !$rose(line_oe)) else $error("alarm raised inside blind time");
endmodule
bind pir_single_wire_readout pir_chk #(.BLIND_UNIT_TICKS(BLIND_UNIT_TICKS)) pir_chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .line_in(line_in), .line_out(line_out),
  .line_oe(line_oe), .adc_value(adc_value), .adc_valid(adc_valid), .adc_short(adc_short)
);
`default_nettype wire

// >>> testbench/pir_host_model.sv
// Host side of the shared readout line: setup, strobes, frame end and clears
`timescale 1ns/1ps
`default_nettype none
module pir_host_model (
  input wire logic hclk, // System clock
  input wire logic line, // Resolved line level
  output logic oe, // High while the host drives
  output logic drv // Host drive level
);
  initial begin
    oe = 1'b0;
    drv = 1'b0;
  end
  task automatic drive(input logic v, input int n);
    oe <= 1'b1;
    drv <= v;
    repeat (n) @(posedge hclk);
  endtask
  // Released line follows the device drive, else falls to the pull-down, never keeps the last level
  task automatic release_line(input int n);
    oe <= 1'b0;
    repeat (n) @(posedge hclk);
  endtask
  // Whole frame far inside 32 ticks, so also before any 512-tick pulse
  // Frames come closer than 2 ms to keep the run short; the block never times it
  task automatic read_frame(input int nbits, output logic [39:0] f);
    f = '0;
    drive(1'b1, 3 * pir_pkg::TICK_CYCLES + 300);
    for (int i = 0; i < nbits; i++) begin
      drive(1'b0, 5);
      drive(1'b1, 6);
      release_line(3);
      f = {f[38:0], line};
    end
  endtask
  task automatic finish_frame();
    drive(1'b0, 10);
    release_line(1);
  endtask
  task automatic hold_low(input int n);
    drive(1'b0, n);
    release_line(1);
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the readout line block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TK = pir_pkg::TICK_CYCLES;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, adc_valid, motion_detect;
  logic line_out, line_oe, adc_short, host_oe, host_drv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [13:0] adc_value, s;
  logic [24:0] cfg;
  logic [39:0] f, ef;
  int n_fail, compares;
  // Host dominates, device next, pull-down when nobody drives
  wire line = host_oe ? host_drv : (line_oe ? line_out : 1'b0);
  always #5 hclk = ~hclk;
  pir_single_wire_readout #(.BLIND_UNIT_TICKS(4)) pir_single_wire_readout_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .line_in(line), .line_out(line_out),
    .line_oe(line_oe), .adc_value(adc_value), .adc_valid(adc_valid),
    .motion_detect(motion_detect), .adc_short(adc_short)
  );
  pir_host_model pir_host_model_i (.hclk(hclk), .line(line), .oe(host_oe), .drv(host_drv));
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic strobe(input logic m, input logic [13:0] v);
    adc_value <= v;
    adc_valid <= !m;
    motion_detect <= m;
    @(posedge hclk);
    adc_valid <= 1'b0;
    motion_detect <= 1'b0;
    repeat (20) @(posedge hclk);
  endtask
  function automatic logic [39:0] frame_of(input logic [24:0] c, input logic [13:0] v);
    return {1'b0, (c[6:5] == pir_pkg::SRC_BAND_PASS) ? 14'(v - 14'h2000) : v, c};
  endfunction
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // About a fifth above the expected run
  initial begin
    repeat (95000) @(posedge hclk);
    n_fail++;
    final_report();
  end
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    adc_value = '0;
    adc_valid = 1'b0;
    motion_detect = 1'b0;
    void'($urandom(32'h6fdc));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, pir_pkg::REG_CONFIG, '0);
    chk("config reset", rd, {7'h00, pir_pkg::CONFIG_RESET});
    bus(1'b0, pir_pkg::REG_SAMPLE, '0);
    chk("sample reset", rd, 32'h000001FF);
    bus(1'b0, 8'h40, '0);
    chk("unmapped", rd, 32'h0);
    strobe(1'b0, 14'h0010);
    chk("short", adc_short, 1'b1);
    bus(1'b0, pir_pkg::REG_SAMPLE, '0);
    chk("low clamp", rd, 32'h000001FF);
    strobe(1'b0, 14'h3FF0);
    bus(1'b0, pir_pkg::REG_SAMPLE, '0);
    chk("high clamp", rd, 32'h00003E01);
    strobe(1'b1, '0);
    chk("forced quiet", line, 1'b0);
    $display("test range done");
    for (int i = 0; i < 2; i++) begin
      cfg = {8'($urandom), 8'($urandom), pir_pkg::MODE_FORCED, 2'(i), 5'h10};
      bus(1'b1, pir_pkg::REG_CONFIG, {7'h00, cfg});
      bus(1'b0, pir_pkg::REG_CONFIG, '0);
      chk("config", rd, {7'h00, cfg});
      s = 14'(511 + $urandom_range(15362));
      strobe(1'b0, s);
      // Second pass stops after the sample bits, then aborts
      pir_host_model_i.read_frame(i ? 15 : 40, f);
      ef = frame_of(cfg, s);
      chk("frame", i ? f[14:0] : f, i ? ef[39:25] : ef);
      if (i == 0) pir_host_model_i.finish_frame();
      else pir_host_model_i.hold_low(5 * TK);
      repeat (2 * TK + 100) @(posedge hclk);
      chk("released", line_oe, 1'b0);
      bus(1'b0, pir_pkg::REG_STATUS, '0);
      chk("status", {rd[pir_pkg::ST_ABORT], rd[pir_pkg::ST_BUSY]}, {1'(i), 1'b0});
      $display("test readout %0d done", i);
    end
    bus(1'b1, pir_pkg::REG_STATUS, 32'h00000001 << pir_pkg::ST_ABORT);
    bus(1'b0, pir_pkg::REG_STATUS, '0);
    chk("abort clear", rd[pir_pkg::ST_ABORT], 1'b0);
    cfg = {8'h20, 8'h00, pir_pkg::MODE_WAKE, pir_pkg::SRC_BAND_PASS, 5'h10};
    bus(1'b1, pir_pkg::REG_CONFIG, {7'h00, cfg});
    for (int j = 0; j < 3; j++) begin
      strobe(1'b1, '0);
      chk("alarm", line, j != 1);
      if (j != 1) begin
        repeat (200) @(posedge hclk);
        chk("alarm held", line, 1'b1);
        pir_host_model_i.hold_low(TK + 200);
        repeat (20) @(posedge hclk);
        chk("alarm cleared", line_oe, 1'b0);
      end
      repeat ((j == 1 ? 5 : 1) * TK) @(posedge hclk);
    end
    $display("test wake done");
    final_report();
  end
endmodule
`default_nettype wire
